/* File: rtl/dma4_pkg.sv */
// package for the four-channel dma controller: register map, fields, states, types
// assumes a single 50 MHz clock domain and an apb register port
package dma4_pkg;
  localparam int          NumCh        = 4;
  localparam int          CountW       = 14;  // largest block 16,384 bytes; count-1 fits in 14 bits
  localparam int          MarkPeriod   = 128;
  localparam logic [7:0]  ChAddrBase   = 8'h00; // channel n address at base + 8*n
  localparam logic [7:0]  ChCountBase  = 8'h04; // channel n count/type at base + 8*n
  localparam logic [7:0]  ChStride     = 8'h08;
  localparam logic [7:0]  ModeOff      = 8'h20;
  localparam logic [7:0]  StatusOff    = 8'h24;
  localparam int          TypeLsb      = 14;  // count register: [13:0] count-1, [15:14] type
  localparam int          ExtWrBit     = 4;   // mode register: [3:0] enables, [4] ext write
  localparam int          BusyBit      = 4;   // status register: [3:0] done flags, [4] busy
  localparam logic [15:0] AddrRst      = 16'h0000;
  localparam logic [15:0] CountRst     = 16'h0000;
  localparam logic [4:0]  ModeRst      = 5'h00;
  localparam logic [6:0]  MarkRst      = 7'h00;

  typedef enum logic [1:0] {
    XferVerify = 2'b00,
    XferWrite  = 2'b01,
    XferRead   = 2'b10
  } xfer_t;

  // gray codes along idle, s0, s1, s2, s3, s4; wait state hangs off s3
  typedef enum logic [2:0] {
    StIdle = 3'b000,
    StS0   = 3'b001,
    StS1   = 3'b011,
    StS2   = 3'b010,
    StS3   = 3'b110,
    StS4   = 3'b111,
    StWait = 3'b100
  } state_t;

  // active-low bus strobes
  typedef struct packed {
    logic memRdN;
    logic memWrN;
    logic ioRdN;
    logic ioWrN;
  } strobes_t;

  localparam strobes_t StrobesIdle = 4'hF;
endpackage : dma4_pkg

/* File: rtl/four_channel_dma_controller.sv */
// four-channel dma controller: bus hold handshake, priority, address and strobe sequencing
// assumes pins synchronous to clk_sys; channels are programmed over apb
//
// Behaviour
// R1 - four channels, each with own cycle count; peripheral told when count completes
// R2 - any enabled request raises the one shared hold request line
// R3 - several pending requests: fixed priority, only the winner served each cycle
// R4 - 16-bit address formed; low byte driven on own address pins
// R5 - high address byte put on data bus; outside latch holds it for the cycle
// R6 - bus kept and cycles repeated while request stays high, until terminal count
// R7 - terminal count output goes high when a channel's count runs out
// R8 - read, write and verify transfer types per channel
// R9 - verify cycles sequence addresses and acknowledges but raise no strobes
// R10 - each channel moves up to 16,384 bytes without processor help
// R11 - mark output pulses once every 128 transfer cycles of the channel
// R12 - ready sampled in s3 and each wait state; s4 only when ready seen (verify cycles here go to s4 without sampling ready)
// R13 - read strobe from s2 until the following s1 or idle state
// R14 - extended write spans s2 to s4; normal write spans s3 to s4
// R15 - on request enter s0, raise hold, resolve priority until grant returns
// R16 - after grant the winning channel's acknowledge is driven low
// R17 - without ready at s3, wait states are inserted until it arrives (verify cycles here never wait)
// R18 - write type: io read at s2, memory write at s3; read type mirrored
// R19 - after reset idle, all outputs inactive, bus released
// R20 - address enable high while the controller owns the bus
`timescale 1ns/1ps
module four_channel_dma_controller (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // system bus side
  output logic             busHoldRequest,
  input  wire logic        busHoldGrant,
  input  wire logic [3:0]  channelRequestIn,
  output logic [3:0]       channelAcknowledgeOutN,
  input  wire logic        ready,
  output logic [7:0]       addrLow,
  output logic             addrOe,
  output logic [7:0]       dataOut,
  output logic             dataOe,
  output logic             upperAddressStrobe,
  output logic             addressEnableOut,
  output logic             memoryReadStrobeN,
  output logic             memoryWriteStrobeN,
  output logic             ioReadStrobeN,
  output logic             ioWriteStrobeN,
  output logic             strobeOe,
  output logic             terminalCountFlag,
  output logic             markOut
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [15:0]          chAddr_r  [dma4_pkg::NumCh];
  logic [15:0]          chAddr_nxt[dma4_pkg::NumCh];
  logic [15:0]          chCount_r  [dma4_pkg::NumCh];
  logic [15:0]          chCount_nxt[dma4_pkg::NumCh];
  logic [6:0]           chMark_r  [dma4_pkg::NumCh];
  logic [6:0]           chMark_nxt[dma4_pkg::NumCh];
  logic [4:0]           mode_r, mode_nxt;
  logic [3:0]           doneFlags_r, doneFlags_nxt;
  dma4_pkg::state_t     state_r, state_nxt;
  logic [1:0]           chan_r, chan_nxt;
  logic                 lastCycle_r, lastCycle_nxt;
  logic                 pready_r, pready_nxt;
  logic [31:0]          prdata_r, prdata_nxt;
  logic                 pslverr_r, pslverr_nxt;
  dma4_pkg::strobes_t   strobes_r, strobes_nxt;
  logic                 hold_r, hold_nxt;
  logic [3:0]           ackN_r, ackN_nxt;
  logic [7:0]           addrLow_r, addrLow_nxt;
  logic                 busOwn_r, busOwn_nxt;
  logic [7:0]           dataOut_r, dataOut_nxt;
  logic                 dataOe_r, dataOe_nxt;
  logic                 upperStb_r, upperStb_nxt;
  logic                 countEnd_r, countEnd_nxt;
  logic                 mark_r, mark_nxt;

  logic [3:0]           pending;
  logic                 anyPending;
  logic [1:0]           winner;
  logic [2:0]           regIdx;
  logic                 chSel;
  logic                 mapped;
  logic [31:0]          rdVal;
  dma4_pkg::xfer_t      curType;
  logic                 extWr;

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    for (int i = 0; i < dma4_pkg::NumCh; i++) begin
      chAddr_nxt[i]  = chAddr_r[i];
      chCount_nxt[i] = chCount_r[i];
      chMark_nxt[i]  = chMark_r[i];
    end
    mode_nxt      = mode_r;
    doneFlags_nxt = doneFlags_r;
    state_nxt     = state_r;
    chan_nxt      = chan_r;
    lastCycle_nxt = lastCycle_r;
    pready_nxt    = 1'b0;
    prdata_nxt    = prdata_r;
    pslverr_nxt   = 1'b0;
    curType       = dma4_pkg::xfer_t'(chCount_r[chan_r][dma4_pkg::TypeLsb +: 2]);
    extWr         = mode_r[dma4_pkg::ExtWrBit];

    // disabled channels never reach the hold logic
    pending    = channelRequestIn & mode_r[3:0];
    anyPending = |pending; // see R2
    winner     = 2'd0;
    for (int i = dma4_pkg::NumCh - 1; i >= 0; i--) begin
      if (pending[i]) begin
        winner = 2'(i); // see R3
      end
    end

    // apb: answer on the second access cycle so prdata can come from a flop
    regIdx = 3'(paddr[4:3]);
    chSel  = (paddr < dma4_pkg::ModeOff) && (paddr[1:0] == 2'b00);
    mapped = chSel || paddr == dma4_pkg::ModeOff || paddr == dma4_pkg::StatusOff;
    rdVal  = 32'h0000_0000;
    if (chSel && !paddr[2]) begin
      rdVal = {16'h0000, chAddr_r[regIdx[1:0]]};
    end else if (chSel) begin
      rdVal = {16'h0000, chCount_r[regIdx[1:0]]};
    end else if (paddr == dma4_pkg::ModeOff) begin
      rdVal = {27'h0000000, mode_r};
    end else if (paddr == dma4_pkg::StatusOff) begin
      rdVal = {27'h0000000, busOwn_r || hold_r, doneFlags_r};
    end
    if (psel && penable && !pready_r) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !mapped;
      prdata_nxt  = pwrite ? 32'h0000_0000 : rdVal;
    end
    if (psel && penable && pready_r && pwrite && mapped) begin
      if (chSel && !paddr[2]) begin
        chAddr_nxt[regIdx[1:0]] = pwdata[15:0];
      end else if (chSel) begin
        chCount_nxt[regIdx[1:0]] = pwdata[15:0];
        chMark_nxt[regIdx[1:0]]  = dma4_pkg::MarkRst;
      end else if (paddr == dma4_pkg::ModeOff) begin
        mode_nxt = pwdata[4:0];
      end else begin
        doneFlags_nxt = doneFlags_r & ~pwdata[3:0];
      end
    end

    // transfer sequencer
    case (state_r)
      dma4_pkg::StIdle: begin
        if (anyPending) begin
          state_nxt = dma4_pkg::StS0; // see R15
        end
      end
      dma4_pkg::StS0: begin
        chan_nxt = winner; // see R3
        if (!anyPending) begin
          state_nxt = dma4_pkg::StIdle;
        end else if (busHoldGrant) begin
          state_nxt = dma4_pkg::StS1; // see R15
        end
      end
      dma4_pkg::StS1: begin
        state_nxt     = dma4_pkg::StS2;
        lastCycle_nxt = chCount_r[chan_r][dma4_pkg::CountW-1:0] == 14'h0000;
      end
      dma4_pkg::StS2: begin
        state_nxt = dma4_pkg::StS3;
      end
      dma4_pkg::StS3, dma4_pkg::StWait: begin
        // verify cycles move no data, so they never wait
        if (ready || curType == dma4_pkg::XferVerify) begin
          state_nxt = dma4_pkg::StS4; // see R12
        end else begin
          state_nxt = dma4_pkg::StWait; // see R17
        end
      end
      dma4_pkg::StS4: begin
        chAddr_nxt[chan_r] = chAddr_r[chan_r] + 16'h0001;
        chMark_nxt[chan_r] = chMark_r[chan_r] + 7'h01;
        if (lastCycle_r) begin
          // the exhausted channel is disabled so it cannot restart on its own
          mode_nxt[chan_r]      = 1'b0;
          doneFlags_nxt[chan_r] = 1'b1; // see R1
        end else begin
          chCount_nxt[chan_r][dma4_pkg::CountW-1:0] =
            chCount_r[chan_r][dma4_pkg::CountW-1:0] - 14'h0001; // see R1
        end
        if (busHoldGrant && (pending & ~(lastCycle_r ? (4'h1 << chan_r) : 4'h0)) != 4'h0) begin
          // keep the bus while any request stays up; after a last cycle only if another channel's request wins; the winner is chosen afresh
          state_nxt = dma4_pkg::StS1; // see R6
          chan_nxt  = winner;
          if (lastCycle_r && winner == chan_r) begin
            state_nxt = dma4_pkg::StIdle;
          end
        end else begin
          state_nxt = dma4_pkg::StIdle;
        end
      end
      default: begin
        state_nxt = dma4_pkg::StIdle;
      end
    endcase

    // pins are derived from the next state so that each flop matches its state
    hold_nxt    = state_nxt != dma4_pkg::StIdle; // see R2
    busOwn_nxt  = state_nxt != dma4_pkg::StIdle && state_nxt != dma4_pkg::StS0; // see R20
    ackN_nxt    = 4'hF;
    addrLow_nxt = addrLow_r;
    dataOut_nxt = dataOut_r;
    dataOe_nxt  = 1'b0;
    upperStb_nxt = 1'b0;
    strobes_nxt = dma4_pkg::StrobesIdle;
    countEnd_nxt = 1'b0;
    mark_nxt    = 1'b0;
    if (busOwn_nxt) begin
      ackN_nxt[chan_nxt] = 1'b0; // see R16
      addrLow_nxt        = chAddr_nxt[chan_nxt][7:0]; // see R4
    end
    if (state_nxt == dma4_pkg::StS1) begin
      dataOut_nxt = chAddr_nxt[chan_nxt][15:8]; // see R5
      dataOe_nxt  = 1'b1;
      upperStb_nxt = 1'b1; // see R5
    end
    if (state_nxt == dma4_pkg::StS3 || state_nxt == dma4_pkg::StWait ||
        state_nxt == dma4_pkg::StS4) begin
      countEnd_nxt = lastCycle_nxt; // see R7
      mark_nxt  = chMark_r[chan_r] == 7'(dma4_pkg::MarkPeriod - 1); // see R11
    end
    if (busOwn_nxt && state_nxt != dma4_pkg::StS1) begin
      // read class from s2; write class from s3, or s2 when extended
      case (curType) // see R8
        dma4_pkg::XferWrite: begin
          strobes_nxt.ioRdN  = 1'b0; // see R13
          strobes_nxt.memWrN = !(state_nxt != dma4_pkg::StS2 || extWr); // see R14
        end
        dma4_pkg::XferRead: begin
          strobes_nxt.memRdN = 1'b0; // see R18
          strobes_nxt.ioWrN  = !(state_nxt != dma4_pkg::StS2 || extWr); // see R18
        end
        default: begin
          strobes_nxt = dma4_pkg::StrobesIdle; // see R9
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  for (genvar g = 0; g < dma4_pkg::NumCh; g++) begin : gChan
    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        chAddr_r[g]  <= dma4_pkg::AddrRst;
        chCount_r[g] <= dma4_pkg::CountRst; // see R10
        chMark_r[g]  <= dma4_pkg::MarkRst;
      end else begin
        chAddr_r[g]  <= chAddr_nxt[g];
        chCount_r[g] <= chCount_nxt[g];
        chMark_r[g]  <= chMark_nxt[g];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      // see R19
      mode_r      <= dma4_pkg::ModeRst;
      doneFlags_r <= 4'h0;
      state_r     <= dma4_pkg::StIdle;
      chan_r      <= 2'd0;
      lastCycle_r <= 1'b0;
      pready_r    <= 1'b0;
      prdata_r    <= 32'h0000_0000;
      pslverr_r   <= 1'b0;
      strobes_r   <= dma4_pkg::StrobesIdle;
      hold_r      <= 1'b0;
      ackN_r      <= 4'hF;
      addrLow_r   <= 8'h00;
      busOwn_r    <= 1'b0;
      dataOut_r   <= 8'h00;
      dataOe_r    <= 1'b0;
      upperStb_r  <= 1'b0;
      countEnd_r  <= 1'b0;
      mark_r      <= 1'b0;
    end else begin
      mode_r      <= mode_nxt;
      doneFlags_r <= doneFlags_nxt;
      state_r     <= state_nxt;
      chan_r      <= chan_nxt;
      lastCycle_r <= lastCycle_nxt;
      pready_r    <= pready_nxt;
      prdata_r    <= prdata_nxt;
      pslverr_r   <= pslverr_nxt;
      strobes_r   <= strobes_nxt;
      hold_r      <= hold_nxt;
      ackN_r      <= ackN_nxt;
      addrLow_r   <= addrLow_nxt;
      busOwn_r    <= busOwn_nxt;
      dataOut_r   <= dataOut_nxt;
      dataOe_r    <= dataOe_nxt;
      upperStb_r  <= upperStb_nxt;
      countEnd_r  <= countEnd_nxt;
      mark_r      <= mark_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready                 = pready_r;
  assign prdata                 = prdata_r;
  assign pslverr                = pslverr_r;
  assign busHoldRequest         = hold_r;
  assign channelAcknowledgeOutN = ackN_r;
  assign addrLow                = addrLow_r;
  assign addrOe                 = busOwn_r;
  assign dataOut                = dataOut_r;
  assign dataOe                 = dataOe_r;
  assign upperAddressStrobe     = upperStb_r;
  assign addressEnableOut       = busOwn_r;
  assign memoryReadStrobeN      = strobes_r.memRdN;
  assign memoryWriteStrobeN     = strobes_r.memWrN;
  assign ioReadStrobeN          = strobes_r.ioRdN;
  assign ioWriteStrobeN         = strobes_r.ioWrN;
  assign strobeOe               = busOwn_r;
  assign terminalCountFlag      = countEnd_r;
  assign markOut                = mark_r;
endmodule : four_channel_dma_controller

/* File: test/dma_link_monitor.sv */
// checker for the dma controller pins: hold handshake, strobe spans, address phase
// assumes it is bound into the controller and sees its ports only
`timescale 1ns/1ps
module dma_link_monitor (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       busHoldRequest,
  input wire logic       busHoldGrant,
  input wire logic [3:0] channelAcknowledgeOutN,
  input wire logic       ready,
  input wire logic       upperAddressStrobe,
  input wire logic       dataOe,
  input wire logic       addressEnableOut,
  input wire logic       memoryReadStrobeN,
  input wire logic       memoryWriteStrobeN,
  input wire logic       ioReadStrobeN,
  input wire logic       ioWriteStrobeN,
  input wire logic       terminalCountFlag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_apb_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("apb answer not one cycle after access");
  a_grant_to_ack: assert property (
    busHoldRequest && !addressEnableOut && busHoldGrant |=> addressEnableOut)
    else $error("no cycle start after grant");
  a_ack_onehot: assert property (
    channelAcknowledgeOutN != 4'hF |-> $onehot(~channelAcknowledgeOutN) && addressEnableOut)
    else $error("acknowledge not single or bus not owned");
  a_enable_with_hold: assert property (addressEnableOut |-> busHoldRequest)
    else $error("address enable without hold");
  a_upper_addr_phase: assert property (
    upperAddressStrobe |-> dataOe && addressEnableOut ##1 !upperAddressStrobe && !dataOe)
    else $error("upper address phase wrong");
  a_rd_span: assert property (
    $fell(memoryReadStrobeN) |-> !memoryReadStrobeN [*3] ##[1:20] memoryReadStrobeN)
    else $error("read strobe span wrong");
  a_memwr_span: assert property (
    $fell(memoryWriteStrobeN) |-> !memoryWriteStrobeN [*2] ##[1:20] memoryWriteStrobeN)
    else $error("write strobe span wrong");
  a_io_then_mem: assert property ($fell(memoryWriteStrobeN) |-> !ioReadStrobeN)
    else $error("memory write before io read");
  a_mem_then_io: assert property ($fell(ioWriteStrobeN) |-> !memoryReadStrobeN)
    else $error("io write before memory read");
  // two more low cycles: leaving s3 without ready would release the strobe one early
  a_ready_wait: assert property (
    !ioReadStrobeN && !memoryWriteStrobeN && !ready |=> !memoryWriteStrobeN [*2])
    else $error("cycle left without ready");
  a_end_in_cycle: assert property (
    terminalCountFlag |-> channelAcknowledgeOutN != 4'hF)
    else $error("terminal count outside a cycle");
endmodule : dma_link_monitor
////////////////////////////////////////////////////////////////////////////////
bind four_channel_dma_controller dma_link_monitor dma_link_monitor_inst (
  .clk_sys, .resetn, .psel, .penable, .pready, .busHoldRequest, .busHoldGrant,
  .channelAcknowledgeOutN, .ready, .upperAddressStrobe, .dataOe, .addressEnableOut,
  .memoryReadStrobeN, .memoryWriteStrobeN, .ioReadStrobeN, .ioWriteStrobeN,
  .terminalCountFlag);

/* File: test/bus_partner.sv */
// host and memory side: grants the bus, answers ready, latches the upper address byte
// assumes the controller drives its pins on clk_sys
`timescale 1ns/1ps
module bus_partner (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       busHoldRequest,
  input wire logic       upperAddressStrobe,
  input wire logic [7:0] dataOut,
  input wire logic [1:0] waitCycles,
  output logic           busHoldGrant,
  output logic           ready,
  output logic [7:0]     upperLatch
);
  logic [3:0] cnt_r;
  // counts cycles since the address phase; saturates so idle ready stays high
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busHoldGrant <= 1'b0;
      cnt_r <= 4'hF;
      upperLatch <= 8'h00;
    end else begin
      busHoldGrant <= busHoldRequest;
      cnt_r <= upperAddressStrobe ? 4'h0 : (cnt_r == 4'hF ? cnt_r : cnt_r + 4'h1);
      if (upperAddressStrobe) upperLatch <= dataOut;
    end
  end
  assign ready = (cnt_r >= 4'h1 + {2'b00, waitCycles});
endmodule : bus_partner

/* File: test/tb.sv */
// self-checking bench: apb programming, write, read, verify and priority transfers
// assumes the partner model grants the bus and answers ready
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %0h versus %0h", $time, g, e); end end
module tb;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr, ready;
  logic        busHoldRequest, busHoldGrant, addrOe, dataOe, upperAddressStrobe;
  logic        addressEnableOut, strobeOe, terminalCountFlag, markOut;
  logic        memoryReadStrobeN, memoryWriteStrobeN, ioReadStrobeN, ioWriteStrobeN;
  logic [7:0]  paddr, addrLow, dataOut, upperLatch;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  channelRequestIn, channelAcknowledgeOutN;
  logic [1:0]  waitCycles;
  logic        e;
  int          error_cnt, comparisons;
  four_channel_dma_controller four_channel_dma_controller_inst (.clk_sys, .resetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .busHoldRequest,
    .busHoldGrant, .channelRequestIn, .channelAcknowledgeOutN, .ready, .addrLow, .addrOe,
    .dataOut, .dataOe, .upperAddressStrobe, .addressEnableOut, .memoryReadStrobeN,
    .memoryWriteStrobeN, .ioReadStrobeN, .ioWriteStrobeN, .strobeOe, .terminalCountFlag,
    .markOut);
  bus_partner bus_partner_inst (.clk_sys, .resetn, .busHoldRequest, .upperAddressStrobe,
    .dataOut, .waitCycles, .busHoldGrant, .ready, .upperLatch);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_upper_strobe();
    for (int i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      if (upperAddressStrobe === 1'b1) break;
    end
  endtask : wait_upper_strobe
  task automatic t_reset();
    `CHK({busHoldRequest, addressEnableOut, terminalCountFlag, markOut}, 4'h0)
    `CHK({addrOe, strobeOe, dataOe, upperAddressStrobe, pready, pslverr}, 6'h00)
    `CHK({channelAcknowledgeOutN, memoryReadStrobeN, memoryWriteStrobeN}, 6'h3F)
    apb(1'b0, 8'h24, 32'h0);
    `CHK(q, 32'h0000_0000)
    apb(1'b0, 8'h30, 32'h0);
    `CHK({e, q}, {1'b1, 32'h0000_0000})
  endtask : t_reset
  task automatic t_write();
    logic [15:0] a;
    waitCycles <= 2'd1;
    apb(1'b1, 8'h08, 32'h0000_12FE);
    apb(1'b1, 8'h0C, {16'h0000, 2'b01, 14'd2});
    apb(1'b1, 8'h20, 32'h0000_0002);
    @(posedge clk_sys);
    channelRequestIn <= 4'h2;
    for (int k = 0; k < 3; k++) begin
      a = 16'h12FE + 16'(k);
      wait_upper_strobe();
      `CHK({channelAcknowledgeOutN, addrLow, dataOut}, {4'hD, a[7:0], a[15:8]})
      `CHK({addrOe, strobeOe, addressEnableOut}, 3'h7)
      @(negedge clk_sys);
      `CHK({upperLatch, ioReadStrobeN, memoryWriteStrobeN}, {a[15:8], 2'b01})
      @(negedge clk_sys);
      `CHK({memoryWriteStrobeN, terminalCountFlag}, {1'b0, k == 2})
    end
    @(posedge clk_sys);
    channelRequestIn <= 4'h0;
    repeat (6) @(posedge clk_sys);
    apb(1'b0, 8'h24, 32'h0);
    `CHK(q, 32'h0000_0002)
    apb(1'b0, 8'h08, 32'h0);
    `CHK(q, 32'h0000_1301)
    apb(1'b1, 8'h24, 32'h0000_000F);
  endtask : t_write
  task automatic t_prio();
    waitCycles <= 2'd0;
    apb(1'b1, 8'h00, 32'h0000_4000);
    apb(1'b1, 8'h04, {16'h0000, 2'b10, 14'd0});
    apb(1'b1, 8'h10, 32'h0000_5000);
    apb(1'b1, 8'h14, {16'h0000, 2'b10, 14'd0});
    apb(1'b1, 8'h20, 32'h0000_0015);
    @(posedge clk_sys);
    channelRequestIn <= 4'h5;
    wait_upper_strobe();
    `CHK({channelAcknowledgeOutN, dataOut}, {4'hE, 8'h40})
    @(negedge clk_sys);
    `CHK({memoryReadStrobeN, ioWriteStrobeN}, 2'b00)
    wait_upper_strobe();
    `CHK({channelAcknowledgeOutN, dataOut}, {4'hB, 8'h50})
    @(posedge clk_sys);
    channelRequestIn <= 4'h0;
    repeat (6) @(posedge clk_sys);
  endtask : t_prio
  task automatic t_verify();
    int nAd, nMk, nEnd, nSt;
    nAd = 0;
    nMk = 0;
    nEnd = 0;
    nSt = 0;
    apb(1'b1, 8'h1C, {16'h0000, 2'b00, 14'd127});
    apb(1'b1, 8'h20, 32'h0000_0008);
    @(posedge clk_sys);
    channelRequestIn <= 4'h8;
    for (int i = 0; i < 900; i++) begin
      @(negedge clk_sys);
      nAd += int'(upperAddressStrobe);
      nMk += int'(markOut);
      nEnd += int'(terminalCountFlag);
      nSt += int'({memoryReadStrobeN, memoryWriteStrobeN, ioReadStrobeN, ioWriteStrobeN} != 4'hF);
      if (nEnd > 0 && terminalCountFlag === 1'b0) break;
    end
    `CHK({nAd, nMk, nEnd, nSt}, {32'd128, 32'd2, 32'd2, 32'd0})
    @(posedge clk_sys);
    channelRequestIn <= 4'h0;
  endtask : t_verify
  task automatic wrap_up();
    $display("comparisons %0d, error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, channelRequestIn, waitCycles} = '0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_write();
    t_prio();
    t_verify();
    wrap_up();
  end
endmodule : tb
